//--- design/tpd_pkg.sv
package tpd_pkg;
	// phase count and indices
	localparam int unsigned PHASES = 3;
	localparam int unsigned PH_A   = 0;
	localparam int unsigned PH_B   = 1;
	localparam int unsigned PH_C   = 2;

	// clock and non-overlap timing
	localparam int unsigned CLK_MHZ      = 100;
	localparam int unsigned DEAD_NS      = 50;
	localparam int unsigned DEAD_CYC_RAW = (DEAD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DEAD_CYC     = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;
	localparam int unsigned DEAD_W       = 4;

	// control mode select field encodings
	localparam logic [1:0] MODE_SEL_SIX    = 2'h0;
	localparam logic [1:0] MODE_SEL_THREE  = 2'h1;
	localparam logic [1:0] MODE_SEL_SINGLE = 2'h2;
	localparam logic [1:0] MODE_SEL_INDEP  = 2'h3;

	// hardware strap readings
	localparam logic [1:0] STRAP_GROUND = 2'h0;
	localparam logic [1:0] STRAP_R47K   = 2'h1;
	localparam logic [1:0] STRAP_FLOAT  = 2'h2;
	localparam logic [1:0] STRAP_SUPPLY = 2'h3;

	// commutation state codes (a, b, c)
	localparam logic [2:0] CODE_STOP  = 3'h0;
	localparam logic [2:0] CODE_ALIGN = 3'h7;
	localparam logic [2:0] CODE_STEP1 = 3'h6;
	localparam logic [2:0] CODE_STEP2 = 3'h4;
	localparam logic [2:0] CODE_STEP3 = 3'h5;
	localparam logic [2:0] CODE_STEP4 = 3'h1;
	localparam logic [2:0] CODE_STEP5 = 3'h3;
	localparam logic [2:0] CODE_STEP6 = 3'h2;

	typedef enum {
		TPD_MODE_OFF,
		TPD_MODE_THREE,
		TPD_MODE_SINGLE
	} tpd_mode_e;

	typedef enum logic [1:0] {
		ROLE_OFF,
		ROLE_SRC,
		ROLE_SNK
	} tpd_role_e;

	typedef tpd_role_e [PHASES-1:0] tpd_roles_t;

	// per-phase logic inputs
	typedef struct packed {
		logic [PHASES-1:0] highIn;
		logic [PHASES-1:0] lowIn;
	} tpd_inputs_s;

	// per-phase gate commands
	typedef struct packed {
		logic [PHASES-1:0] upper;
		logic [PHASES-1:0] lower;
	} tpd_gates_s;
endpackage

//--- design/tpd_gate_guard.sv
`timescale 1ns/1ns
module tpd_gate_guard (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// requested gate levels
	input  wire logic reqUpper,
	input  wire logic reqLower,
	// gate commands
	output logic      upperGate_r,
	output logic      lowerGate_r
);
	import tpd_pkg::*;

	logic [DEAD_W-1:0] deadCnt_r;
	logic              turnOff;
	logic              deadDone;
	logic              upperGate_nxt;
	logic              lowerGate_nxt;

	// a gate turning off opens the non-overlap gap
	assign turnOff  = (upperGate_r & ~reqUpper) | (lowerGate_r & ~reqLower);
	assign deadDone = (deadCnt_r == '0);

	// turn-on only after the gap and with the opposite gate off
	assign upperGate_nxt = reqUpper & ~reqLower &
		(upperGate_r | (~lowerGate_r & deadDone & ~turnOff));
	assign lowerGate_nxt = reqLower & ~reqUpper &
		(lowerGate_r | (~upperGate_r & deadDone & ~turnOff));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			upperGate_r <= 1'b0;
			lowerGate_r <= 1'b0;
		end else begin
			upperGate_r <= upperGate_nxt;
			lowerGate_r <= lowerGate_nxt;
		end
	end

	// gap counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			deadCnt_r <= '0;
		end else if (turnOff) begin
			deadCnt_r <= DEAD_W'(DEAD_CYC);
		end else if (!deadDone) begin
			deadCnt_r <= deadCnt_r - DEAD_W'(1);
		end
	end
endmodule

//--- design/tpd_decoder.sv
// How it works
// - three-input mode on select field 01b or strap at 47 kilohm to ground
// - three-input, low input high: PWM low drives lower gate, high drives upper
// - three-input, low input low: both gates of that phase off
// - single-PWM mode on select field 10b or floating strap
// - phase A high input PWM sets frequency and duty of active bridges
// - in single-PWM mode three inputs form the commutation state code
// - code 000 stops all gates; 111 aligns A driven, B and C low on
// - six forward codes: source high follows PWM, low complement, sink low on
// - freewheel select keeps source lower gate off, upper switches with PWM
// - synchronous by default; freewheel select only on serial variants
// - direction high selects each step by complement of forward code
// - brake low: all upper gates off, all lower gates on
// - brake overrides PWM, state and direction inputs
`timescale 1ns/1ns
module tpd_decoder (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// configuration
	input  wire logic               serialVariant,
	input  wire logic [1:0]         modeSelect,
	input  wire logic [1:0]         strapLevel,
	input  wire logic               freewheelSelect,
	// logic inputs from the controller
	input  wire tpd_pkg::tpd_inputs_s phaseIn,
	// gate commands
	output tpd_pkg::tpd_gates_s     gates,
	// decoded mode
	output logic                    threeModeOut,
	output logic                    singleModeOut
);
	import tpd_pkg::*;

	tpd_mode_e         mode_r;
	tpd_mode_e         mode_nxt;
	logic              freewheel_r;
	logic              singlePwm;
	logic [2:0]        stateCode;
	logic              directionIn;
	logic              brakeIn_n;
	logic [2:0]        lookupCode;
	tpd_roles_t        roles;
	logic [PHASES-1:0] reqUpper;
	logic [PHASES-1:0] reqLower;

	// six-step table, forward codes only
	function automatic tpd_roles_t stepRoles(input logic [2:0] code);
		tpd_roles_t r;
		r = '{default: ROLE_OFF};
		if (code == CODE_ALIGN) begin
			r[PH_A] = ROLE_SRC;
			r[PH_B] = ROLE_SNK;
			r[PH_C] = ROLE_SNK;
		end else if (code == CODE_STEP1) begin
			r[PH_B] = ROLE_SRC;
			r[PH_C] = ROLE_SNK;
		end else if (code == CODE_STEP2) begin
			r[PH_A] = ROLE_SRC;
			r[PH_C] = ROLE_SNK;
		end else if (code == CODE_STEP3) begin
			r[PH_A] = ROLE_SRC;
			r[PH_B] = ROLE_SNK;
		end else if (code == CODE_STEP4) begin
			r[PH_C] = ROLE_SRC;
			r[PH_B] = ROLE_SNK;
		end else if (code == CODE_STEP5) begin
			r[PH_C] = ROLE_SRC;
			r[PH_A] = ROLE_SNK;
		end else if (code == CODE_STEP6) begin
			r[PH_B] = ROLE_SRC;
			r[PH_A] = ROLE_SNK;
		end
		return r;
	endfunction

	// mode from select field or strap
	always_comb begin
		mode_nxt = TPD_MODE_OFF;
		if (serialVariant) begin
			if (modeSelect == MODE_SEL_THREE) begin
				mode_nxt = TPD_MODE_THREE;
			end else if (modeSelect == MODE_SEL_SINGLE) begin
				mode_nxt = TPD_MODE_SINGLE;
			end
		end else if (strapLevel == STRAP_R47K) begin
			mode_nxt = TPD_MODE_THREE;
		end else if (strapLevel == STRAP_FLOAT) begin
			mode_nxt = TPD_MODE_SINGLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_r <= TPD_MODE_OFF;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// freewheel only honoured on serial variants
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			freewheel_r <= 1'b0;
		end else begin
			freewheel_r <= serialVariant & freewheelSelect;
		end
	end

	// mode indication
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			threeModeOut  <= 1'b0;
			singleModeOut <= 1'b0;
		end else begin
			threeModeOut  <= (mode_r == TPD_MODE_THREE);
			singleModeOut <= (mode_r == TPD_MODE_SINGLE);
		end
	end

	// single-PWM input roles
	assign singlePwm   = phaseIn.highIn[PH_A];
	assign stateCode   = {phaseIn.lowIn[PH_A], phaseIn.highIn[PH_B], phaseIn.lowIn[PH_B]};
	assign directionIn = phaseIn.highIn[PH_C];
	assign brakeIn_n   = phaseIn.lowIn[PH_C];
	// reverse steps only; stop and align keep their codes
	assign lookupCode  = (directionIn && stateCode != CODE_STOP && stateCode != CODE_ALIGN) ?
		~stateCode : stateCode;
	assign roles       = stepRoles(lookupCode);

	// per-phase gate requests
	always_comb begin
		reqUpper = '0;
		reqLower = '0;
		for (int i = 0; i < PHASES; i++) begin
			if (mode_r == TPD_MODE_THREE) begin
				if (phaseIn.lowIn[i]) begin
					reqUpper[i] = phaseIn.highIn[i];
					reqLower[i] = ~phaseIn.highIn[i];
				end
			end else if (mode_r == TPD_MODE_SINGLE) begin
				if (!brakeIn_n) begin
					reqLower[i] = 1'b1;
				end else if (roles[i] == ROLE_SRC) begin
					reqUpper[i] = singlePwm;
					reqLower[i] = ~singlePwm & ~freewheel_r;
				end else if (roles[i] == ROLE_SNK) begin
					reqLower[i] = 1'b1;
				end
			end
		end
	end

	// non-overlap guard per phase
	genvar g;
	generate
		for (g = 0; g < PHASES; g++) begin : gPhase
			tpd_gate_guard uGuard (
				.clk         (clk),
				.rst_n       (rst_n),
				.reqUpper    (reqUpper[g]),
				.reqLower    (reqLower[g]),
				.upperGate_r (gates.upper[g]),
				.lowerGate_r (gates.lower[g])
			);
		end
	endgenerate

	// checks
	AST_NO_SHOOT: assert property (@(posedge clk) disable iff (!rst_n)
		(gates.upper & gates.lower) == '0)
		else $error("upper and lower gate on together");

	AST_MODE_THREE: assert property (@(posedge clk) disable iff (!rst_n)
		(serialVariant && modeSelect == MODE_SEL_THREE) ||
		(!serialVariant && strapLevel == STRAP_R47K) |=> mode_r == TPD_MODE_THREE)
		else $error("three-input mode not entered");

	AST_MODE_SINGLE: assert property (@(posedge clk) disable iff (!rst_n)
		(serialVariant && modeSelect == MODE_SEL_SINGLE) ||
		(!serialVariant && strapLevel == STRAP_FLOAT) |=> ##1 singleModeOut)
		else $error("single-PWM mode not entered");

	AST_HIZ: assert property (@(posedge clk) disable iff (!rst_n)
		mode_r == TPD_MODE_THREE && !phaseIn.lowIn[PH_A] |=>
		!gates.upper[PH_A] && !gates.lower[PH_A])
		else $error("phase A not high impedance");

	AST_THREE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_r == TPD_MODE_THREE && phaseIn.lowIn[PH_B] && phaseIn.highIn[PH_B])[*8] |=>
		gates.upper[PH_B] && !gates.lower[PH_B])
		else $error("phase B upper gate not following input");

	AST_STOP: assert property (@(posedge clk) disable iff (!rst_n)
		mode_r == TPD_MODE_SINGLE && brakeIn_n && stateCode == CODE_STOP |=>
		gates == '0)
		else $error("stop code left a gate on");

	AST_BRAKE: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_r == TPD_MODE_SINGLE && !brakeIn_n)[*8] |=>
		gates.upper == '0 && gates.lower == '1)
		else $error("brake did not pull all lower gates on");

	AST_FREEWHEEL: assert property (@(posedge clk) disable iff (!rst_n)
		mode_r == TPD_MODE_SINGLE && freewheel_r && brakeIn_n &&
		stateCode == CODE_ALIGN |=> !gates.lower[PH_A])
		else $error("source lower gate switched while freewheeling");

	AST_STEP_ONE: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_r == TPD_MODE_SINGLE && brakeIn_n && lookupCode == CODE_STEP1)[*8] |=>
		gates.lower[PH_C] && !gates.upper[PH_C] && !gates.upper[PH_A] && !gates.lower[PH_A])
		else $error("step one gate pattern wrong");

	AST_REV_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_r == TPD_MODE_SINGLE && brakeIn_n && directionIn && stateCode == CODE_ALIGN)[*8] |=>
		gates.lower[PH_B] && gates.lower[PH_C] && !gates.upper[PH_B] && !gates.upper[PH_C])
		else $error("align code with direction high not aligning");
endmodule

//--- test/tpd_ctrl_model.sv
`timescale 1ns/1ns
module tpd_ctrl_model (
	// clock and control
	input  wire logic                 clk,
	input  wire logic                 idle,
	input  wire logic                 single,
	// three-input levels
	input  wire logic [2:0]           pwm3,
	input  wire logic [2:0]           hiZn,
	// single-pwm levels
	input  wire logic                 pwm,
	input  wire logic [2:0]           hall,
	input  wire logic                 directionInput,
	input  wire logic                 brakeInputN,
	// pins toward the block
	output tpd_pkg::tpd_inputs_s      phaseIn
);
	import tpd_pkg::*;

	always_ff @(posedge clk) begin
		if (idle) begin
			phaseIn <= '0;
		end else if (single) begin
			phaseIn.highIn <= {directionInput, hall[1], pwm};
			phaseIn.lowIn  <= {brakeInputN, hall[0], hall[2]};
		end else begin
			phaseIn.highIn <= pwm3;
			phaseIn.lowIn  <= hiZn;
		end
	end
endmodule

//--- test/tpd_decoder_tb.sv
`timescale 1ns/1ns
module tpd_decoder_tb;
	import tpd_pkg::*;
	logic        clk, rst_n, serialVariant, freewheelSelect, idle, single, pwm;
	logic        directionInput, brakeInputN, threeModeOut, singleModeOut;
	logic [1:0]  modeSelect, strapLevel;
	logic [2:0]  pwm3, hiZn, hall;
	tpd_inputs_s phaseIn;
	tpd_gates_s  gates;
	int          n_fail = 0, compares = 0, cyc = 0;

	tpd_ctrl_model u_tpd_ctrl_model (.clk(clk), .idle(idle), .single(single), .pwm3(pwm3), .hiZn(hiZn),
		.pwm(pwm), .hall(hall), .directionInput(directionInput), .brakeInputN(brakeInputN), .phaseIn(phaseIn));
	tpd_decoder u_tpd_decoder (.clk(clk), .rst_n(rst_n), .serialVariant(serialVariant),
		.modeSelect(modeSelect), .strapLevel(strapLevel), .freewheelSelect(freewheelSelect),
		.phaseIn(phaseIn), .gates(gates), .threeModeOut(threeModeOut), .singleModeOut(singleModeOut));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(string nm, logic [5:0] e, logic [5:0] g);
		compares++;
		if (e !== g) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// expected gates: source/sink masks per code, bit0 = phase a
	function automatic logic [5:0] expG(logic [2:0] c, logic p, logic asy);
		logic [2:0] s, k;
		case (c)
			CODE_ALIGN: {s, k} = {3'h1, 3'h6};
			CODE_STEP1: {s, k} = {3'h2, 3'h4};
			CODE_STEP2: {s, k} = {3'h1, 3'h4};
			CODE_STEP3: {s, k} = {3'h1, 3'h2};
			CODE_STEP4: {s, k} = {3'h4, 3'h2};
			CODE_STEP5: {s, k} = {3'h4, 3'h1};
			CODE_STEP6: {s, k} = {3'h2, 3'h1};
			default:    {s, k} = 6'h0;
		endcase
		return {(p ? s : 3'h0), (k | ((p | asy) ? 3'h0 : s))};
	endfunction

	task automatic setMode(logic sv, logic [1:0] ms, logic [1:0] st, logic fw, logic sg);
		idle = 1'b1;
		step(4);
		serialVariant = sv;
		modeSelect = ms;
		strapLevel = st;
		freewheelSelect = fw;
		single = sg;
		step(4);
		idle = 1'b0;
		step(8);
	endtask

	task automatic modeChk(logic sv, logic [1:0] ms, logic [1:0] st, logic [1:0] e);
		setMode(sv, ms, st, 1'b0, e[0]);
		chk("mode", {4'h0, e}, {4'h0, threeModeOut, singleModeOut});
	endtask

	task automatic t_modes();
		modeChk(1'b1, MODE_SEL_THREE, STRAP_FLOAT, 2'h2);
		modeChk(1'b1, MODE_SEL_SINGLE, STRAP_R47K, 2'h1);
		modeChk(1'b0, MODE_SEL_SIX, STRAP_R47K, 2'h2);
		modeChk(1'b0, MODE_SEL_SIX, STRAP_FLOAT, 2'h1);
		modeChk(1'b1, MODE_SEL_SIX, STRAP_FLOAT, 2'h0);
		modeChk(1'b1, MODE_SEL_INDEP, STRAP_R47K, 2'h0);
		modeChk(1'b0, MODE_SEL_SINGLE, STRAP_SUPPLY, 2'h0);
	endtask

	task automatic t_three();
		setMode(1'b1, MODE_SEL_THREE, STRAP_GROUND, 1'b0, 1'b0);
		step(10);
		chk("lowOn", {3'h0, 3'h7}, gates);
		pwm3 = 3'h3;
		step(3);
		chk("gap", {3'h0, 3'h4}, gates);
		step(6);
		chk("highOn", {3'h3, 3'h4}, gates);
		hiZn = 3'h6;
		step(10);
		chk("hiZ", {3'h2, 3'h4}, gates);
		hiZn = 3'h7;
		pwm3 = 3'h0;
	endtask

	task automatic t_single(logic d, logic fw, logic sv);
		setMode(sv, MODE_SEL_SINGLE, STRAP_FLOAT, fw, 1'b1);
		directionInput = d;
		for (int c = 0; c < 8; c++) begin
			for (int p = 0; p < 2; p++) begin
				hall = (d && c != 0 && c != 7) ? ~c[2:0] : c[2:0];
				pwm = p[0];
				step(10);
				chk("table", expG(c[2:0], p[0], fw & sv), gates);
			end
		end
		directionInput = 1'b0;
	endtask

	task automatic t_brake();
		setMode(1'b1, MODE_SEL_SINGLE, STRAP_FLOAT, 1'b0, 1'b1);
		hall = CODE_STEP1;
		pwm = 1'b1;
		step(10);
		brakeInputN = 1'b0;
		step(10);
		chk("brake", {3'h0, 3'h7}, gates);
		hall = CODE_ALIGN;
		pwm = 1'b0;
		directionInput = 1'b1;
		step(10);
		chk("brakeHold", {3'h0, 3'h7}, gates);
		brakeInputN = 1'b1;
		directionInput = 1'b0;
		hall = CODE_STOP;
		step(10);
		chk("stop", 6'h0, gates);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (rst_n && |(gates.upper & gates.lower)) begin
			n_fail++;
			$display("CHECK FAILED overlap expected 0 seen %h", gates);
		end
		if (cyc == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		rst_n = 1'b0;
		{serialVariant, freewheelSelect, single, pwm} = 4'h0;
		modeSelect = MODE_SEL_SIX;
		strapLevel = STRAP_GROUND;
		idle = 1'b1;
		pwm3 = 3'h0;
		hall = 3'h0;
		hiZn = 3'h7;
		directionInput = 1'b0;
		brakeInputN = 1'b1;
		step(10);
		rst_n = 1'b1;
		step(2);
		t_modes();
		t_three();
		t_single(1'b0, 1'b0, 1'b1);
		t_single(1'b1, 1'b0, 1'b1);
		t_single(1'b0, 1'b1, 1'b1);
		t_single(1'b0, 1'b1, 1'b0);
		t_brake();
		report_and_stop();
	end
endmodule
